// ---- src/smhs_sequencer.sv ----
// Purpose: Master sequencer for a three, four or five pin synchronous serial port.
// Assumes: Slave pins are asynchronous and are synchronised here.
// Notes: Half bit period is halfBitCycles plus one core clock periods.
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------
// Transmit word queue
// ------------------------------------------------------------------
module smhs_fifo
	#(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
	)
	(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
	);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtrReg, wrPtrNext, rdPtrReg, rdPtrNext;
	logic [AW:0] countReg, countNext;
	logic push, pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : bump

	assign inReady = countReg != (AW + 1)'(DEPTH);
	assign outValid = countReg != '0;
	assign outData = mem[rdPtrReg];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb
	begin
		wrPtrNext = push ? bump(wrPtrReg) : wrPtrReg;
		rdPtrNext = pop ? bump(rdPtrReg) : rdPtrReg;
		countNext = countReg;
		if (push && !pop)
		begin
			countNext = (AW + 1)'(countReg + 1'b1);
		end
		else if (pop && !push)
		begin
			countNext = (AW + 1)'(countReg - 1'b1);
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			wrPtrReg <= '0;
			rdPtrReg <= '0;
			countReg <= '0;
		end
		else
		begin
			wrPtrReg <= wrPtrNext;
			rdPtrReg <= rdPtrNext;
			countReg <= countNext;
		end
	end

	// Storage holds no control state, so it is left out of reset.
	always_ff @(posedge core_clk)
	begin
		if (push)
		begin
			mem[wrPtrReg] <= inData;
		end
	end
endmodule : smhs_fifo

// ------------------------------------------------------------------
// Sequencer top
// ------------------------------------------------------------------
module smhs_sequencer
	import smhs_pkg::*;
	(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic [1:0] pinOption,
	input wire logic clockPolarity,
	input wire logic clockPhase,
	input wire logic holdSelectBetweenWords,
	input wire logic [4:0] selectToClockDelay,
	input wire logic [4:0] endToSelectDelay,
	input wire logic [7:0] halfBitCycles,
	input wire logic [WORD_BITS-1:0] txData,
	input wire logic txValid,
	output logic txReady,
	output logic [WORD_BITS-1:0] rxData,
	output logic rxValid,
	output logic busy,
	output logic serialClockPin,
	output logic serialDataOut,
	input wire logic serialDataIn,
	output logic chipSelectLine_n,
	input wire logic slaveReadyLine_n
	);
	smhs_state_e stateReg, stateNext;
	logic [8:0] cntReg, cntNext;
	logic [7:0] halfReg, halfNext;
	logic [4:0] edgeReg, edgeNext;
	logic [WORD_BITS-1:0] txShiftReg, txShiftNext, rxShiftReg, rxShiftNext;
	logic [WORD_BITS-1:0] rxDataReg, rxDataNext;
	logic rxValidReg, rxValidNext;
	logic sclkReg, sclkNext, mosiReg, mosiNext, csReg, csNext;
	logic readyMetaReg, readyPinReg, misoMetaReg, misoPinReg;
	logic [WORD_BITS-1:0] fifoData;
	logic fifoValid, loadWord, edgeTick, sampleEdge, usesCs, usesEna;
	logic readySeen;
	logic [8:0] halfWide;

	assign usesCs = pinOption[OPT_CS_BIT];
	assign usesEna = pinOption[OPT_ENA_BIT];
	assign readySeen = !readyPinReg;
	assign halfWide = {1'b0, halfBitCycles};

	smhs_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) txQueue (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.inData(txData),
		.inValid(txValid),
		.inReady(txReady),
		.outData(fifoData),
		.outValid(fifoValid),
		.outReady(loadWord)
	);

	// --------------------------------------------------------------
	// Pin synchronisers
	// --------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			readyMetaReg <= READY_PIN_RESET;
			readyPinReg <= READY_PIN_RESET;
			misoMetaReg <= 1'b0;
			misoPinReg <= 1'b0;
		end
		else
		begin
			readyMetaReg <= slaveReadyLine_n;
			readyPinReg <= readyMetaReg;
			misoMetaReg <= serialDataIn;
			misoPinReg <= misoMetaReg;
		end
	end

	// --------------------------------------------------------------
	// Word sequencing
	// --------------------------------------------------------------
	always_comb
	begin
		stateNext = stateReg;
		cntNext = cntReg;
		halfNext = halfReg;
		edgeNext = edgeReg;
		txShiftNext = txShiftReg;
		rxShiftNext = rxShiftReg;
		rxDataNext = rxDataReg;
		rxValidNext = 1'b0;
		sclkNext = sclkReg;
		mosiNext = mosiReg;
		csNext = csReg;
		loadWord = 1'b0;
		edgeTick = 1'b0;
		sampleEdge = 1'b0;
		unique case (stateReg)
			ST_IDLE:
			begin
				sclkNext = clockPolarity;
				if (fifoValid)
				begin
					loadWord = 1'b1;
					csNext = !usesCs;
					cntNext = '0;
					if (usesCs && csReg)
					begin
						cntNext = 9'(CS_TO_CLK_PERIODS + widen5(selectToClockDelay));
					end
					if (!clockPhase)
					begin
						mosiNext = fifoData[WORD_BITS-1];
						txShiftNext = {fifoData[WORD_BITS-2:0], 1'b0};
					end
					else
					begin
						txShiftNext = fifoData;
					end
					stateNext = ST_SELECT;
				end
			end
			ST_SELECT:
			begin
				if (cntReg == '0)
				begin
					stateNext = ST_READY;
				end
				else
				begin
					cntNext = 9'(cntReg - 1'b1);
				end
			end
			ST_READY:
			begin
				// The word stays queued in the shifter while the slave is absent.
				if (!usesEna || readySeen)
				begin
					cntNext = usesEna ? ENA_TO_CLK_PERIODS : '0;
					stateNext = ST_SETTLE;
				end
			end
			ST_SETTLE:
			begin
				if (cntReg == '0)
				begin
					halfNext = clockPhase ? halfBitCycles : 8'h00;
					edgeNext = '0;
					stateNext = ST_SHIFT;
				end
				else
				begin
					cntNext = 9'(cntReg - 1'b1);
				end
			end
			ST_SHIFT:
			begin
				if (halfReg == '0)
				begin
					edgeTick = 1'b1;
					sclkNext = !sclkReg;
					halfNext = halfBitCycles;
					edgeNext = 5'(edgeReg + 1'b1);
					sampleEdge = (!edgeReg[0]) ^ clockPhase;
					if (sampleEdge)
					begin
						rxShiftNext = {rxShiftReg[WORD_BITS-2:0], misoPinReg};
					end
					else if (edgeReg != LAST_EDGE)
					begin
						mosiNext = txShiftReg[WORD_BITS-1];
						txShiftNext = {txShiftReg[WORD_BITS-2:0], 1'b0};
					end
					if (edgeReg == LAST_EDGE)
					begin
						rxDataNext = rxShiftNext;
						rxValidNext = 1'b1;
						// The sync term lets a dropped ready reach the core.
						cntNext = 9'((clockPhase ? 9'h000 : halfWide)
							+ widen5(endToSelectDelay)
							+ (usesEna ? SYNC_STAGES : 9'h000));
						stateNext = ST_TRAIL;
					end
				end
				else
				begin
					halfNext = 8'(halfReg - 1'b1);
				end
			end
			ST_TRAIL:
			begin
				if (cntReg == '0)
				begin
					if (!(holdSelectBetweenWords && fifoValid))
					begin
						csNext = CS_RESET;
					end
					stateNext = ST_IDLE;
				end
				else
				begin
					cntNext = 9'(cntReg - 1'b1);
				end
			end
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			stateReg <= ST_IDLE;
			cntReg <= '0;
			halfReg <= '0;
			edgeReg <= '0;
			txShiftReg <= '0;
			rxShiftReg <= '0;
			rxDataReg <= '0;
			rxValidReg <= 1'b0;
			sclkReg <= 1'b0;
			mosiReg <= 1'b0;
			csReg <= CS_RESET;
		end
		else
		begin
			stateReg <= stateNext;
			cntReg <= cntNext;
			halfReg <= halfNext;
			edgeReg <= edgeNext;
			txShiftReg <= txShiftNext;
			rxShiftReg <= rxShiftNext;
			rxDataReg <= rxDataNext;
			rxValidReg <= rxValidNext;
			sclkReg <= sclkNext;
			mosiReg <= mosiNext;
			csReg <= csNext;
		end
	end

	assign serialClockPin = sclkReg;
	assign serialDataOut = mosiReg;
	assign chipSelectLine_n = csReg;
	assign rxData = rxDataReg;
	assign rxValid = rxValidReg;
	assign busy = stateReg != ST_IDLE;

	// --------------------------------------------------------------
	// Spacing monitors and checks
	// --------------------------------------------------------------
	logic [8:0] csAgeReg, csAgeNext, rdyAgeReg, rdyAgeNext;
	logic [8:0] sinceEdgeReg, sinceEdgeNext;

	always_comb
	begin
		csAgeNext = csReg ? '0 : ((csAgeReg == AGE_MAX) ? csAgeReg
			: 9'(csAgeReg + 1'b1));
		rdyAgeNext = !readySeen ? '0 : ((rdyAgeReg == AGE_MAX) ? rdyAgeReg
			: 9'(rdyAgeReg + 1'b1));
		sinceEdgeNext = edgeTick ? '0 : ((sinceEdgeReg == AGE_MAX)
			? sinceEdgeReg : 9'(sinceEdgeReg + 1'b1));
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			csAgeReg <= '0;
			rdyAgeReg <= '0;
			sinceEdgeReg <= AGE_MAX;
		end
		else
		begin
			csAgeReg <= csAgeNext;
			rdyAgeReg <= rdyAgeNext;
			sinceEdgeReg <= sinceEdgeNext;
		end
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	a_ena_lead_gap: assert property (
		(edgeTick && edgeReg == '0 && usesEna) |-> rdyAgeReg >= ENA_TO_CLK_PERIODS)
		else $error("first edge too soon after ready");
	a_cs_lead_gap: assert property (
		(edgeTick && edgeReg == '0 && usesCs) |->
		csAgeReg >= 9'(CS_TO_CLK_PERIODS + widen5(selectToClockDelay)))
		else $error("first edge too soon after select");
	a_cs_trail_gap: assert property (
		(stateReg == ST_TRAIL && cntReg == '0 && csNext && !csReg) |->
		sinceEdgeReg >= 9'((clockPhase ? 9'h000 : halfWide)
		+ widen5(endToSelectDelay)))
		else $error("select released too soon after last edge");
	a_hold_select: assert property (
		(stateReg == ST_TRAIL && cntReg == '0 && holdSelectBetweenWords
		&& fifoValid && !csReg) |=> !csReg ##1 !csReg)
		else $error("select dropped while holding");
	a_five_pin_both: assert property (
		(edgeTick && edgeReg == '0 && pinOption == 2'b11) |->
		(!csReg && rdyAgeReg != '0))
		else $error("five pin start without select and ready");
	a_first_edge_dir: assert property (
		(edgeTick && edgeReg == '0) |=> (sclkReg != clockPolarity)
		&& $changed(sclkReg))
		else $error("first edge in wrong direction");
	a_wait_ready: assert property (
		(stateReg == ST_READY && usesEna && !readySeen) |=>
		(stateReg == ST_READY && sclkReg == clockPolarity))
		else $error("left ready wait without ready");
	a_last_bit_hold: assert property (
		(stateReg != ST_SHIFT && !loadWord) |=> $stable(serialDataOut))
		else $error("data output changed between words");
	a_word_length: assert property (
		edgeTick |-> (edgeReg == '0 || sinceEdgeReg == halfWide)
		##1 (rxValid == ($past(edgeReg) == LAST_EDGE)))
		else $error("edge spacing or word end wrong");
endmodule : smhs_sequencer

`default_nettype wire

// ---- src/smhs_pkg.sv ----
// Purpose: Constants and types for the serial master handshake sequencer.
// Assumes: All delays are counted in core_clk periods.
// Notes: Pin option bit 0 enables the ready handshake, bit 1 chip select.
//
// Overview of operation
// - With ready handshake, first clock edge waits three periods after ready seen.
// - Chip select leads the first edge by two periods, plus half bit when phase 1.
// - Chip select release trails the final edge by half bit when phase 0.
// - Hold-select with queued data keeps chip select asserted between words.
// - Select-to-clock field adds periods between chip select assertion and the first clock edge.
// - End-to-select field adds periods before chip select release.
// - Five-pin option applies both the select and ready spacings together.
// - Polarity 0 starts rising and ends falling; polarity 1 the reverse.
// - Last data bit stays on the output until a new word is loaded.
package smhs_pkg;

	// --------------------------------------------------------------
	// Sizes and spacings
	// --------------------------------------------------------------
	localparam int WORD_BITS = 16;
	localparam int FIFO_DEPTH = 8;
	localparam logic [4:0] LAST_EDGE = 5'h1f;
	localparam logic [8:0] CS_TO_CLK_PERIODS = 9'h002;
	localparam logic [8:0] ENA_TO_CLK_PERIODS = 9'h003;
	localparam logic [8:0] SYNC_STAGES = 9'h002;
	localparam logic [8:0] AGE_MAX = 9'h1ff;
	localparam int OPT_ENA_BIT = 0;
	localparam int OPT_CS_BIT = 1;

	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam logic CS_RESET = 1'b1;
	localparam logic READY_PIN_RESET = 1'b1;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_SELECT = 6'h02,
		ST_READY = 6'h04,
		ST_SETTLE = 6'h08,
		ST_SHIFT = 6'h10,
		ST_TRAIL = 6'h20
	} smhs_state_e;

	function automatic logic [8:0] widen5(input logic [4:0] v);
		widen5 = {4'h0, v};
	endfunction : widen5

endpackage : smhs_pkg

// ---- test/smhs_slave_model.sv ----
// Purpose: Behavioural serial slave facing the master sequencer.
// Assumes: Pins are sampled on core_clk; the reply word is fixed.
// Notes: Ready drops before the last edge of each word, returns later.
`timescale 1ns/10ps
`default_nettype none
module smhs_slave_model
	#(
	parameter logic [15:0] REPLY = 16'ha5c3
	)
	(
	input wire logic core_clk,
	input wire logic serialClockPin,
	input wire logic chipSelectLine_n,
	input wire logic useSelect,
	input wire logic clockPolarity,
	input wire logic clockPhase,
	input wire logic allowReady,
	output logic slaveReadyLine_n,
	output logic serialDataIn
	);
	logic clkSeen = 1'b0;
	logic readyReg = 1'b1;
	logic lastBit = 1'b0;
	logic [5:0] edges = 6'h00;
	logic [4:0] quiet = 5'h00;
	logic [3:0] idx;
	logic bitNow;
	logic selected;
	logic edgeNow;
	assign idx = clockPhase ? 4'((edges - 6'h01) >> 1) : edges[4:1];
	assign bitNow = REPLY[4'hf - idx];
	assign selected = !chipSelectLine_n || !useSelect;
	assign edgeNow = (serialClockPin != clkSeen)
		&& (edges != 6'h00 || clkSeen == clockPolarity);
	// A deselected slave leaves the line floating, shown as the inverse.
	assign serialDataIn = selected ? bitNow : ~lastBit;
	assign slaveReadyLine_n = readyReg;
	always @(posedge core_clk)
	begin
		clkSeen <= serialClockPin;
		if (selected)
			lastBit <= bitNow;
		if (edgeNow)
			edges <= (edges == 6'h1f) ? 6'h00 : edges + 6'h01;
		if (edgeNow && edges == 6'h1e)
			quiet <= 5'h14;
		else if (quiet != 5'h00)
			quiet <= quiet - 5'h01;
		readyReg <= !(allowReady && quiet == 5'h00)
			|| (edgeNow && edges == 6'h1e);
	end
endmodule : smhs_slave_model
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench for the serial master sequencer.
// Assumes: One core_clk period is 5 ns; a half bit is 12 periods.
// Notes: Spacings are minima counted in core periods at the pins.
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import smhs_pkg::*;
	;
	localparam int HB = 12;
	localparam logic [15:0] REPLY = 16'ha5c3;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [1:0] opt = 2'h0;
	logic pol = 1'b0;
	logic pha = 1'b0;
	logic hold = 1'b0;
	logic allow = 1'b0;
	logic txValid = 1'b0;
	logic [4:0] sd = 5'h00;
	logic [4:0] ed = 5'h00;
	logic [15:0] txData = 16'h0000;
	logic txReady, rxValid, busy, sclk, mosi, csn, rdyN, miso;
	logic [15:0] rxData;
	logic [15:0] moWord;
	logic sclkD, csnD, rdyD, firstVal;
	int nMismatch = 0;
	int nChecks = 0;
	int cyc = 0;
	int nTog, nRise, nRx, tFirst, tLast, tCs, tRise, tRdy;
	always #2.5 core_clk = ~core_clk;
	smhs_sequencer dut_u (.core_clk(core_clk), .reset_n(reset_n),
		.pinOption(opt), .clockPolarity(pol), .clockPhase(pha),
		.holdSelectBetweenWords(hold), .selectToClockDelay(sd),
		.endToSelectDelay(ed), .halfBitCycles(8'h0b), .txData(txData),
		.txValid(txValid), .txReady(txReady), .rxData(rxData),
		.rxValid(rxValid), .busy(busy), .serialClockPin(sclk),
		.serialDataOut(mosi), .serialDataIn(miso),
		.chipSelectLine_n(csn), .slaveReadyLine_n(rdyN));
	smhs_slave_model slave_u (.core_clk(core_clk), .serialClockPin(sclk),
		.chipSelectLine_n(csn), .useSelect(opt[1]), .clockPolarity(pol),
		.clockPhase(pha), .allowReady(allow), .slaveReadyLine_n(rdyN),
		.serialDataIn(miso));
	// Pin watcher; the move to idle level after reset is not an edge.
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		sclkD <= sclk;
		csnD <= csn;
		rdyD <= rdyN;
		if (sclk !== sclkD && (nTog != 0 || sclkD === pol))
		begin
			if (nTog == 0)
				tFirst <= cyc;
			if (nTog == 0)
				firstVal <= sclk;
			if (((nTog % 2) == 0) != pha)
				moWord <= {moWord[14:0], mosi};
			tLast <= cyc;
			nTog <= nTog + 1;
		end
		if (csnD === 1'b1 && csn === 1'b0)
			tCs <= cyc;
		if (csnD === 1'b0 && csn === 1'b1)
			nRise <= nRise + 1;
		if (csnD === 1'b0 && csn === 1'b1)
			tRise <= cyc;
		if (rdyD === 1'b1 && rdyN === 1'b0 && nTog == 0)
			tRdy <= cyc;
		if (rxValid === 1'b1)
			nRx <= nRx + 1;
		// Counters start afresh with every reset of the block.
		if (reset_n !== 1'b1)
		begin
			nTog <= 0;
			nRise <= 0;
			nRx <= 0;
		end
		if (cyc > 20000)
		begin
			nMismatch++;
			report_and_stop();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		nChecks++;
		if (got !== exp)
		begin
			nMismatch++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask : chk
	task automatic chk_min(input string what, input int lo, input int got);
		chk(what, (got < lo) ? lo : got, got);
	endtask : chk_min
	task automatic setup(input logic [1:0] o, input logic pl, input logic ph,
		input logic h, input logic [4:0] s, input logic [4:0] e,
		input logic a);
		@(posedge core_clk);
		reset_n <= 1'b0;
		opt <= o;
		pol <= pl;
		pha <= ph;
		hold <= h;
		sd <= s;
		ed <= e;
		allow <= a;
		repeat (5) @(posedge core_clk);
		reset_n <= 1'b1;
	endtask : setup
	task automatic push(input logic [15:0] d);
		logic ok;
		txData <= d;
		txValid <= 1'b1;
		ok = 1'b0;
		while (ok !== 1'b1)
		begin
			@(negedge core_clk);
			ok = txReady;
			@(posedge core_clk);
		end
	endtask : push
	// Busy drops for a single cycle between queued words, so idle must last.
	task automatic wait_idle();
		int nQuiet;
		nQuiet = 0;
		while (nQuiet < 8)
		begin
			@(posedge core_clk);
			nQuiet = (busy === 1'b0) ? nQuiet + 1 : 0;
		end
	endtask : wait_idle
	task automatic t_select_gap();
		setup(2'h2, 1'b0, 1'b0, 1'b0, 5'h05, 5'h03, 1'b0);
		push(16'h1235);
		txValid <= 1'b0;
		wait_idle();
		chk_min("select to clock", 2 + 5, tFirst - tCs);
		chk("first level", 1'h1, firstVal);
		chk("last level", 1'h0, sclk);
		chk("edge count", 32, nTog);
		chk("data out", 16'h1235, moWord);
		chk("data in", REPLY, rxData);
		chk("rx pulses", 1, nRx);
		chk_min("clock to release", HB + 3, tRise - tLast);
		chk("held bit", 1'h1, mosi);
	endtask : t_select_gap
	task automatic t_ready_fill();
		int nTake;
		setup(2'h1, 1'b1, 1'b1, 1'b0, 5'h00, 5'h00, 1'b0);
		nTake = 0;
		txData <= 16'hc00f;
		txValid <= 1'b1;
		repeat (40)
		begin
			@(negedge core_clk);
			if (txReady === 1'b1)
				nTake++;
			@(posedge core_clk);
		end
		txValid <= 1'b0;
		chk("words taken", 9, nTake);
		chk("idle clock", 1'h1, sclk);
		chk("edges held", 0, nTog);
		allow <= 1'b1;
		wait_idle();
		chk_min("ready to clock", 3 + HB, tFirst - tRdy);
		chk("first level", 1'h0, firstVal);
		chk("last level", 1'h1, sclk);
		chk("edge count", 9 * 32, nTog);
		chk("data out", 16'hc00f, moWord);
		chk("data in", REPLY, rxData);
		chk("rx pulses", 9, nRx);
		chk("held bit", 1'h1, mosi);
	endtask : t_ready_fill
	task automatic t_five_hold();
		setup(2'h3, 1'b0, 1'b1, 1'b1, 5'h00, 5'h02, 1'b1);
		push(16'h0f0f);
		push(16'h5aa4);
		txValid <= 1'b0;
		wait_idle();
		chk("select releases", 1, nRise);
		chk("edge count", 64, nTog);
		chk("rx pulses", 2, nRx);
		chk_min("select to clock", 2 + HB, tFirst - tCs);
		chk_min("ready to clock", 3 + HB, tFirst - tRdy);
		chk_min("end to release", 2, tRise - tLast);
		chk("data out", 16'h5aa4, moWord);
		chk("held bit", 1'h0, mosi);
	endtask : t_five_hold
	task automatic t_three_pin();
		setup(2'h0, 1'b1, 1'b0, 1'b0, 5'h00, 5'h00, 1'b0);
		push(16'h6b52);
		txValid <= 1'b0;
		wait_idle();
		chk("select idle", 1'h1, csn);
		chk("select releases", 0, nRise);
		chk("first level", 1'h0, firstVal);
		chk("last level", 1'h1, sclk);
		chk("edge count", 32, nTog);
		chk("data out", 16'h6b52, moWord);
		chk("data in", REPLY, rxData);
		chk("rx pulses", 1, nRx);
		chk("held bit", 1'h0, mosi);
	endtask : t_three_pin
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", nChecks, nMismatch);
		if (nMismatch == 0 && nChecks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	initial
	begin
		t_select_gap();
		t_ready_fill();
		t_five_hold();
		t_three_pin();
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
